// *** design/tcr_core.sv ***
// temperature channel compensation select and recalibration request logic
`timescale 1ns/1ps
module tcr_core (
    input wire logic core_clk,
    input wire logic srst,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    input wire tcr_pkg::tcr_sample_s sample,
    output logic [7:0] gain_code,
    output logic [7:0] offset_code,
    output logic comp_valid,
    output logic comp_is_ext,
    output logic recal_irq,
    output logic wakeup,
    output logic [15:0] latest_chip_temp,
    output logic voltage_auto_gain,
    output logic current_auto_gain,
    output logic voltage_chopper_enable
);
    tcr_pkg::tcr_state_s st;
    tcr_pkg::tcr_state_s next_st;
    logic addr_ph;
    logic out_range;
    logic recal_event;
    logic wr;
    logic [7:0] wb;

    function automatic logic [31:0] rd_mux(input tcr_pkg::tcr_state_s s,
                                           input logic [7:0] a);
        logic [31:0] d;
        d = 32'h0000_0000;
        unique case (a)
            tcr_pkg::off_comp_control: d[2:0] = s.ctl;
            tcr_pkg::off_temp_comp_config: begin
                d[2:0] = s.out_of_range_count_limit;
                d[tcr_pkg::bit_auto_gain] = s.auto_gain_temp_comp_enable;
            end
            tcr_pkg::off_comp_status: d[0] = s.recal_request_flag;
            tcr_pkg::off_upper_temp_threshold: d[7:0] = s.upper_temp_threshold;
            tcr_pkg::off_lower_temp_threshold: d[7:0] = s.lower_temp_threshold;
            tcr_pkg::off_int_gain: d[7:0] = s.internal_sensor_gain_code;
            tcr_pkg::off_int_offset: d[7:0] = s.internal_sensor_offset_code;
            tcr_pkg::off_ext_gain: d[7:0] = s.external_sensor_gain_code;
            tcr_pkg::off_ext_offset: d[7:0] = s.external_sensor_offset_code;
            tcr_pkg::off_count: d[tcr_pkg::cnt_w-1:0] = s.count;
            default: d = 32'h0000_0000;
        endcase
        return d;
    endfunction

    // a chip temperature result is the only input that moves the counter
    function automatic logic chip_result(input tcr_pkg::tcr_sample_s s);
        return s.valid && !s.is_ext;
    endfunction

    // ----------------------------------------------------------------
    // bus slave: zero wait state, write data taken in data phase
    // ----------------------------------------------------------------
    assign addr_ph = hsel && hready && (htrans == tcr_pkg::htrans_nonseq);
    assign wr = st.wr_pend;
    assign wb = hwdata[7:0];
    // only the high byte is compared; low byte is below threshold grain
    assign out_range = (sample.code[15:8] > st.upper_temp_threshold) ||
        (sample.code[15:8] < st.lower_temp_threshold);

    always_comb begin
        next_st = st;
        next_st.wr_pend = addr_ph && hwrite;
        next_st.wr_addr = addr_ph ? haddr[7:0] : st.wr_addr;
        if (wr) begin
            unique case (st.wr_addr)
                tcr_pkg::off_comp_control: begin
                    for (int i = 0; i < 3; i++) begin
                        if (hwdata[tcr_pkg::mask_shift + i]) begin
                            next_st.ctl[i] = hwdata[i];
                        end
                    end
                end
                tcr_pkg::off_temp_comp_config: begin
                    next_st.out_of_range_count_limit = hwdata[2:0];
                    next_st.auto_gain_temp_comp_enable =
                        hwdata[tcr_pkg::bit_auto_gain];
                end
                tcr_pkg::off_upper_temp_threshold:
                    next_st.upper_temp_threshold = wb;
                tcr_pkg::off_lower_temp_threshold:
                    next_st.lower_temp_threshold = wb;
                tcr_pkg::off_int_gain: next_st.internal_sensor_gain_code = wb;
                tcr_pkg::off_int_offset:
                    next_st.internal_sensor_offset_code = wb;
                tcr_pkg::off_ext_gain: next_st.external_sensor_gain_code = wb;
                tcr_pkg::off_ext_offset:
                    next_st.external_sensor_offset_code = wb;
                default: ;
            endcase
        end
        // ------------------------------------------------------------
        // compensation code select per result
        // ------------------------------------------------------------
        next_st.comp_valid = sample.valid;
        next_st.comp_is_ext = sample.is_ext;
        // scaling to 524 K or half supply is analog; codes drive it
        if (!st.ctl[tcr_pkg::bit_temp_comp]) begin
            next_st.gain_code = tcr_pkg::default_temp_gain_code;
            next_st.offset_code = tcr_pkg::default_temp_offset_code;
        end else if (sample.is_ext) begin
            next_st.gain_code = st.external_sensor_gain_code;
            next_st.offset_code = st.external_sensor_offset_code;
        end else begin
            next_st.gain_code = st.internal_sensor_gain_code;
            next_st.offset_code = st.internal_sensor_offset_code;
        end
        // ------------------------------------------------------------
        // out-of-range tracking counter
        // ------------------------------------------------------------
        recal_event = 1'b0;
        if (chip_result(sample)) begin
            next_st.latest_chip_temp = sample.code;
            if (out_range) begin
                if (st.count != tcr_pkg::cnt_max) begin
                    next_st.count = st.count + tcr_pkg::cnt_one;
                end
            end else if (st.count != tcr_pkg::cnt_zero) begin
                next_st.count = st.count - tcr_pkg::cnt_one;
            end
            recal_event = (next_st.count >
                {1'b0, st.out_of_range_count_limit}) &&
                !st.auto_gain_temp_comp_enable;
        end
        if (wr && st.wr_addr == tcr_pkg::off_comp_status && hwdata[0]) begin
            next_st.recal_request_flag = 1'b0;
        end
        // set beats a same-cycle clear
        if (recal_event) begin
            next_st.recal_request_flag = 1'b1;
        end
        next_st.recal_irq = next_st.recal_request_flag &&
            next_st.ctl[tcr_pkg::bit_recal_ie];
        next_st.wakeup = next_st.recal_irq;
        next_st.auto_gain_active = next_st.auto_gain_temp_comp_enable;
        // read data sees a write landing on this edge, so a write followed
        // at once by a read of the same register returns the new value
        next_st.hrdata = (addr_ph && !hwrite) ?
            rd_mux(next_st, haddr[7:0]) : 32'h0000_0000;
    end

    always_ff @(posedge core_clk) begin
        if (srst) begin
            st <= '0;
            st.upper_temp_threshold <= tcr_pkg::rst_threshold_upper;
            st.lower_temp_threshold <= tcr_pkg::rst_threshold_lower;
            st.internal_sensor_gain_code <= tcr_pkg::default_temp_gain_code;
            st.external_sensor_gain_code <= tcr_pkg::default_temp_gain_code;
            st.gain_code <= tcr_pkg::default_temp_gain_code;
        end else begin
            st <= next_st;
        end
    end

    assign hrdata = st.hrdata;
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
    assign gain_code = st.gain_code;
    assign offset_code = st.offset_code;
    assign comp_valid = st.comp_valid;
    assign comp_is_ext = st.comp_is_ext;
    assign recal_irq = st.recal_irq;
    assign wakeup = st.wakeup;
    assign latest_chip_temp = st.latest_chip_temp;
    // one enable feeds both chains together
    assign voltage_auto_gain = st.auto_gain_active;
    assign current_auto_gain = st.auto_gain_active;
    assign voltage_chopper_enable = st.ctl[tcr_pkg::bit_vchop];

    // ----------------------------------------------------------------
    // assertions
    // ----------------------------------------------------------------
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (srst);

    // ----------------------------------------------------------------
    // register bus
    // ----------------------------------------------------------------
    idle_rdata_a: assert property (
        !(addr_ph && !hwrite) |=> hrdata == 32'h0000_0000)
        else $error("read data outside data phase");
    upper_write_a: assert property (
        wr && st.wr_addr == tcr_pkg::off_upper_temp_threshold |=>
        st.upper_temp_threshold == $past(hwdata[7:0]))
        else $error("upper threshold write lost");
    lower_write_a: assert property (
        wr && st.wr_addr == tcr_pkg::off_lower_temp_threshold |=>
        st.lower_temp_threshold == $past(hwdata[7:0]))
        else $error("lower threshold write lost");
    gain_write_a: assert property (
        wr && st.wr_addr == tcr_pkg::off_int_gain |=>
        st.internal_sensor_gain_code == $past(hwdata[7:0]))
        else $error("internal gain write lost");
    limit_write_a: assert property (
        wr && st.wr_addr == tcr_pkg::off_temp_comp_config |=>
        st.out_of_range_count_limit == $past(hwdata[2:0]))
        else $error("count limit write lost");
    mask_write_a: assert property (
        wr && st.wr_addr == tcr_pkg::off_comp_control |=>
        st.ctl == (($past(st.ctl) & ~$past(hwdata[tcr_pkg::mask_shift +: 3]))
        | ($past(hwdata[2:0]) & $past(hwdata[tcr_pkg::mask_shift +: 3]))))
        else $error("mask ignored");

    // ----------------------------------------------------------------
    // applied codes
    // ----------------------------------------------------------------
    default_codes_a: assert property (
        sample.valid && !st.ctl[tcr_pkg::bit_temp_comp] |=>
        gain_code == tcr_pkg::default_temp_gain_code &&
        offset_code == tcr_pkg::default_temp_offset_code)
        else $error("default codes wrong");
    int_codes_a: assert property (
        chip_result(sample) && st.ctl[tcr_pkg::bit_temp_comp] |=>
        gain_code == $past(st.internal_sensor_gain_code) &&
        offset_code == $past(st.internal_sensor_offset_code))
        else $error("internal codes not applied");
    ext_codes_a: assert property (
        sample.valid && sample.is_ext && st.ctl[tcr_pkg::bit_temp_comp] |=>
        gain_code == $past(st.external_sensor_gain_code) &&
        offset_code == $past(st.external_sensor_offset_code))
        else $error("external codes not applied");
    comp_copy_a: assert property (
        sample.valid |=> comp_valid && comp_is_ext == $past(sample.is_ext))
        else $error("result tag not copied");

    // ----------------------------------------------------------------
    // out-of-range counter
    // ----------------------------------------------------------------
    count_up_a: assert property (
        chip_result(sample) && out_range && st.count != tcr_pkg::cnt_max |=>
        st.count == $past(st.count) + tcr_pkg::cnt_one)
        else $error("counter did not rise");
    count_sat_a: assert property (
        chip_result(sample) && out_range && st.count == tcr_pkg::cnt_max |=>
        st.count == tcr_pkg::cnt_max)
        else $error("counter wrapped at the top");
    count_down_a: assert property (
        chip_result(sample) && !out_range && st.count != tcr_pkg::cnt_zero
        |=> st.count == $past(st.count) - tcr_pkg::cnt_one)
        else $error("counter did not fall");
    count_floor_a: assert property (
        chip_result(sample) && !out_range && st.count == tcr_pkg::cnt_zero
        |=> st.count == tcr_pkg::cnt_zero)
        else $error("counter wrapped");
    count_hold_a: assert property (
        !chip_result(sample) |=> st.count == $past(st.count))
        else $error("counter moved without a chip result");

    // ----------------------------------------------------------------
    // request, flag, interrupt and wake-up
    // ----------------------------------------------------------------
    req_set_a: assert property (
        chip_result(sample) && out_range && !st.auto_gain_temp_comp_enable &&
        st.count >= {1'b0, st.out_of_range_count_limit} |=>
        st.recal_request_flag)
        else $error("request not raised");
    no_req_agc_a: assert property (
        st.auto_gain_temp_comp_enable && !st.recal_request_flag |=>
        !st.recal_request_flag)
        else $error("request under auto gain");
    flag_sticky_a: assert property (
        st.recal_request_flag && !wr |=> st.recal_request_flag)
        else $error("flag dropped");
    flag_clear_a: assert property (
        wr && st.wr_addr == tcr_pkg::off_comp_status && hwdata[0] &&
        !recal_event |=> !st.recal_request_flag)
        else $error("flag not cleared");
    irq_gate_a: assert property (
        recal_irq == (st.recal_request_flag && st.ctl[tcr_pkg::bit_recal_ie]))
        else $error("irq ungated");
    wake_a: assert property (
        wakeup == recal_irq)
        else $error("no wakeup");
    latest_temp_a: assert property (
        chip_result(sample) |=> latest_chip_temp == $past(sample.code))
        else $error("latest chip result not kept");
    auto_both_a: assert property (
        voltage_auto_gain == current_auto_gain &&
        voltage_auto_gain == st.auto_gain_temp_comp_enable)
        else $error("auto gain chains differ");

    req_c: cover property (recal_event);
    clear_c: cover property (st.recal_request_flag ##1 !st.recal_request_flag);
    ext_c: cover property (sample.valid && sample.is_ext);
    sat_c: cover property (st.count == tcr_pkg::cnt_max);
    agc_quiet_c: cover property (chip_result(sample) && out_range &&
        st.auto_gain_temp_comp_enable);
endmodule

// *** design/tcr_pkg.sv ***
// package: register map, field layout and types of the temperature recal block
package tcr_pkg;
    localparam logic [7:0] default_temp_gain_code = 8'h80;
    localparam logic [7:0] default_temp_offset_code = 8'h00;
    localparam int cnt_w = 4;
    localparam logic [cnt_w-1:0] cnt_zero = 4'h0;
    localparam logic [cnt_w-1:0] cnt_one = 4'h1;
    localparam logic [cnt_w-1:0] cnt_max = 4'hf;
    // register byte offsets
    localparam logic [7:0] off_comp_control = 8'h00;
    localparam logic [7:0] off_temp_comp_config = 8'h04;
    localparam logic [7:0] off_comp_status = 8'h08;
    localparam logic [7:0] off_upper_temp_threshold = 8'h0c;
    localparam logic [7:0] off_lower_temp_threshold = 8'h10;
    localparam logic [7:0] off_int_gain = 8'h14;
    localparam logic [7:0] off_int_offset = 8'h18;
    localparam logic [7:0] off_ext_gain = 8'h1c;
    localparam logic [7:0] off_ext_offset = 8'h20;
    localparam logic [7:0] off_count = 8'h24;
    // comp_control: value bits [2:0], companion mask bits [10:8]
    localparam int bit_temp_comp = 0;
    localparam int bit_recal_ie = 1;
    localparam int bit_vchop = 2;
    localparam int mask_shift = 8;
    // temp_comp_config: limit [2:0], auto gain enable [4]
    localparam int bit_auto_gain = 4;
    localparam logic [1:0] htrans_nonseq = 2'b10;
    localparam logic [7:0] rst_threshold_upper = 8'hff;
    localparam logic [7:0] rst_threshold_lower = 8'h00;
    localparam logic [8:0] agc_room_code = 9'h000;

    typedef struct packed {
        logic [2:0] ctl;
        logic [2:0] out_of_range_count_limit;
        logic auto_gain_temp_comp_enable;
        logic recal_request_flag;
        logic [7:0] upper_temp_threshold;
        logic [7:0] lower_temp_threshold;
        logic [7:0] internal_sensor_gain_code;
        logic [7:0] internal_sensor_offset_code;
        logic [7:0] external_sensor_gain_code;
        logic [7:0] external_sensor_offset_code;
        logic [cnt_w-1:0] count;
        logic [7:0] wr_addr;
        logic wr_pend;
        logic [31:0] hrdata;
        logic [7:0] gain_code;
        logic [7:0] offset_code;
        logic comp_valid;
        logic comp_is_ext;
        logic recal_irq;
        logic wakeup;
        logic [15:0] latest_chip_temp;
        logic auto_gain_active;
    } tcr_state_s;

    typedef struct packed {
        logic valid;
        logic is_ext;
        logic [15:0] code;
    } tcr_sample_s;
endpackage

// *** dv/temp_comp_recal_request_tb.sv ***
// self-checking bench of the temperature recal block against a bench model
`timescale 1ns/1ps
`define CHK(got, exp) begin checked++; if ((got) !== (exp)) begin \
    bad_count++; $display("CHECK FAILED t=%0t got=%h exp=%h", $time, \
    (got), (exp)); end end

module temp_comp_recal_request_tb;
// ----------------------------------------------------------------
// signals and model state
// ----------------------------------------------------------------
logic core_clk, srst, hsel, hwrite, hready, hreadyout, hresp;
logic [31:0] haddr, hwdata, hrdata, r, d;
logic [1:0] htrans;
logic [2:0] hsize;
tcr_pkg::tcr_sample_s sample;
logic [7:0] gain_code, offset_code;
logic comp_valid, comp_is_ext, recal_irq, wakeup;
logic voltage_auto_gain, current_auto_gain, voltage_chopper_enable;
logic [15:0] latest_chip_temp, latest;
int bad_count, checked, seed, op, a;
// model registers by word index; mask bits of control never stored
logic [31:0] m [0:10];

assign hready = hreadyout;

tcr_core u_tcr_core (.core_clk(core_clk), .srst(srst), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
    .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .sample(sample),
    .gain_code(gain_code), .offset_code(offset_code),
    .comp_valid(comp_valid), .comp_is_ext(comp_is_ext),
    .recal_irq(recal_irq), .wakeup(wakeup),
    .latest_chip_temp(latest_chip_temp),
    .voltage_auto_gain(voltage_auto_gain),
    .current_auto_gain(current_auto_gain),
    .voltage_chopper_enable(voltage_chopper_enable));

always #2 core_clk = ~core_clk;

// ----------------------------------------------------------------
// bus and sample tasks
// ----------------------------------------------------------------
task automatic bus(input logic w, input logic [7:0] ad, input logic [31:0] wd);
    @(posedge core_clk);
    hsel <= 1'b1;
    haddr <= {24'h0, ad};
    htrans <= tcr_pkg::htrans_nonseq;
    hwrite <= w;
    @(posedge core_clk);
    while (hready !== 1'b1) @(posedge core_clk);
    htrans <= 2'b00;
    hwdata <= wd;
    @(posedge core_clk);
    while (hready !== 1'b1) @(posedge core_clk);
    r = hrdata;
endtask

task automatic do_rd(input logic [7:0] ad);
    bus(1'b0, ad, 32'h0);
    `CHK(r & ((ad == 8'h00) ? 32'h7 : 32'hffffffff), m[ad[7:2]])
    `CHK(hresp, 1'b0)
    `CHK(hreadyout, 1'b1)
endtask

task automatic do_wr(input logic [7:0] ad, input logic [31:0] wd);
    bus(1'b1, ad, wd);
    case (ad)
        tcr_pkg::off_comp_control: begin
            for (int i = 0; i < 3; i++) begin
                if (wd[8+i]) m[0][i] = wd[i];
            end
        end
        tcr_pkg::off_temp_comp_config: m[1] = wd & 32'h17;
        tcr_pkg::off_comp_status: if (wd[0]) m[2] = 32'h0;
        // counter and unmapped words ignore writes
        default: if (ad < tcr_pkg::off_count) m[ad[7:2]] = wd & 32'hff;
    endcase
endtask

task automatic do_sample(input logic ext, input logic [15:0] code);
    @(posedge core_clk);
    sample <= {1'b1, ext, code};
    @(posedge core_clk);
    sample.valid <= 1'b0;
    #1;
    if (!ext) begin
        if (code[15:8] > m[3][7:0] || code[15:8] < m[4][7:0]) begin
            if (m[9] < 15) m[9] = m[9] + 1;
        end else if (m[9] > 0) begin
            m[9] = m[9] - 1;
        end
        if (!m[1][4] && m[9] > m[1][2:0]) m[2] = 32'h1;
        latest = code;
    end
    `CHK(comp_valid, 1'b1)
    `CHK(comp_is_ext, ext)
    `CHK(gain_code, m[0][0] ? m[ext ? 7 : 5][7:0] : 8'h80)
    `CHK(offset_code, m[0][0] ? m[ext ? 8 : 6][7:0] : 8'h00)
    `CHK(recal_irq, m[2][0] & m[0][1])
    `CHK(wakeup, m[2][0] & m[0][1])
    `CHK(latest_chip_temp, latest)
    `CHK(voltage_auto_gain, m[1][4])
    `CHK(current_auto_gain, m[1][4])
    `CHK(voltage_chopper_enable, m[0][2])
endtask

task automatic model_reset;
    for (int i = 0; i <= 10; i++) m[i] = 32'h0;
    m[3] = 32'hff;
    m[5] = 32'h80;
    m[7] = 32'h80;
    latest = 16'h0;
endtask

// outputs one edge after release, then every register word
task automatic check_resets;
    @(posedge core_clk);
    #1;
    `CHK(gain_code, 8'h80)
    `CHK(offset_code, 8'h00)
    `CHK({comp_valid, recal_irq, wakeup, voltage_auto_gain}, 4'h0)
    `CHK(latest_chip_temp, 16'h0)
    `CHK(hrdata, 32'h0)
    for (a = 0; a <= 40; a += 4) do_rd(8'(a));
endtask

task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0) begin
        $display("All checks passed");
    end else begin
        $display("Checks failed");
    end
    $finish;
endtask

// ----------------------------------------------------------------
// main sequence
// ----------------------------------------------------------------
initial begin
    core_clk = 1'b0;
    srst = 1'b1;
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'b00;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0;
    sample = '0;
    seed = 49;
    model_reset;
    repeat (4) @(posedge core_clk);
    srst <= 1'b0;
    check_resets;
    $display("test reset_values done");
    // boundary: high byte equal to a threshold counts as in range
    do_wr(8'h0c, 32'h40);
    do_wr(8'h10, 32'h40);
    do_wr(8'h00, 32'h303);
    do_sample(1'b0, 16'h40ff);
    do_sample(1'b0, 16'h4100);
    do_sample(1'b0, 16'h3fff);
    do_rd(8'h24);
    do_wr(8'h08, 32'h1);
    do_sample(1'b1, 16'h1234);
    $display("test threshold_edges done");
    // reset in mid-run with auto gain on and the counter moved
    do_wr(8'h04, 32'h13);
    do_sample(1'b0, 16'hff00);
    @(posedge core_clk);
    srst <= 1'b1;
    repeat (2) @(posedge core_clk);
    srst <= 1'b0;
    model_reset;
    check_resets;
    $display("test midrun_reset done");
    // software answers a request with new codes and a new window
    do_wr(8'h00, 32'h703);
    do_wr(8'h04, 32'h2);
    do_wr(8'h0c, 32'h8a);
    do_wr(8'h10, 32'h8a);
    repeat (3) do_sample(1'b0, 16'h9000);
    do_rd(8'h08);
    do_wr(8'h14, 32'h7f);
    do_wr(8'h18, 32'h03);
    do_wr(8'h0c, 32'h98);
    do_wr(8'h10, 32'h8a);
    do_wr(8'h08, 32'h1);
    do_sample(1'b0, 16'h9000);
    $display("test recal_service done");
    // chopper on pairs with auto gain; requests then stay quiet
    do_wr(8'h00, 32'h404);
    do_wr(8'h04, 32'h12);
    repeat (5) do_sample(1'b0, 16'hff00);
    do_rd(8'h08);
    do_wr(8'h00, 32'h400);
    do_wr(8'h04, 32'h2);
    $display("test auto_gain_quiet done");
    // random mix reaches every offset, unmapped 28h included
    for (int i = 0; i < 600; i++) begin
        op = {$random(seed)} % 10;
        a = 4 * ({$random(seed)} % 11);
        d = $random(seed);
        if (op < 5) do_sample(d[16], d[15:0]);
        else if (op < 8) do_wr(8'(a), d);
        else do_rd(8'(a));
    end
    $display("test random_mix done");
    tally_and_finish;
end

// about 1700 cycles expected; a hang is cut at 25000
initial begin
    #100000;
    bad_count++;
    tally_and_finish;
end
endmodule
